//--- hdl/scw_map.svh
// Constants of the supervisor: control bits, defaults and timings
`ifndef SCW_MAP_SVH
`define SCW_MAP_SVH

`define SCW_CLK_PERIOD_NS  4
`define SCW_TICK_US        1000
`define SCW_WAKE_MIN_US    50

`define SCW_B_WD_OFF1      0
`define SCW_B_TRK_LO       2
`define SCW_B_TRK_HI       7
`define SCW_B_SLEEP        8
`define SCW_B_WD_OFF2      9
`define SCW_B_DLY_A        10
`define SCW_B_DLY_B        11
`define SCW_B_WIN_A        12
`define SCW_B_WIN_B        13
`define SCW_B_WD_OFF3      14
`define SCW_B_KICK         15

`define SCW_CTRL_DEFAULT   16'h4dfd

`define SCW_DLY_64MS       8'h40
`define SCW_DLY_32MS       8'h20
`define SCW_DLY_16MS       8'h10
`define SCW_DLY_8MS        8'h08
`define SCW_WIN_128MS      8'h80
`define SCW_WIN_64MS       8'h40
`define SCW_WIN_32MS       8'h20
`define SCW_WIN_16MS       8'h10
`define SCW_SETTLE_MS      2'h2

`endif

//--- hdl/scw_pkg.sv
// Types shared by the supervisor modules
package scw_pkg;

	typedef enum logic [2:0] {
		SCW_WD_OFF,
		SCW_WD_WAIT,
		SCW_WD_CLOSED,
		SCW_WD_OPEN,
		SCW_WD_FAULT
	} scw_wd_state_t;

	typedef struct packed {
		logic [15:0] rx;
		logic [15:0] tx;
		logic [15:0] word;
		logic [5:0]  cnt;
		logic        sclk_d;
		logic        cs_d;
		logic        done;
	} scw_spi_st_t;

	typedef struct packed {
		logic [15:0]      ctrl;
		logic [17:0]      tick_cnt;
		logic [17:0]      wake_cnt;
		logic             powered;
		logic             reg_on;
		logic [2:0]       rst_act;
		logic [2:0][7:0]  rst_cnt;
		scw_wd_state_t    wd;
		logic [7:0]       wd_cnt;
		logic [7:0]       win_len;
		logic             ret1;
		logic             ret2;
		logic             err_l;
		logic             wd_err;
		logic [1:0]       settle;
		logic [5:0]       trk_prev;
		logic             fault_n;
	} scw_top_st_t;

endpackage : scw_pkg

//--- hdl/scw_sync.sv
// Three-stage input synchroniser; a bit changes once stages two and three agree
`timescale 1ns/100ps
module scw_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} scw_sync_st_t;

	scw_sync_st_t s;
	scw_sync_st_t n;

	always_comb begin
		n    = s;
		n.s1 = d;
		n.s2 = s.s1;
		n.s3 = s.s2;
		// Only the later stages are compared; s1 may still be metastable
		n.q  = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
		end else begin
			s <= n;
		end
	end

	assign q = s.q;
endmodule : scw_sync

//--- hdl/scw_serial.sv
// Serial port engine: LSB-first shift in and out, word taken on chip select release
`timescale 1ns/100ps
module scw_serial
	import scw_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        di,
	input  wire logic [15:0] diag,
	output logic      [15:0] word,
	output logic             done,
	output logic             sdo,
	output logic             sdo_oe
);
	scw_spi_st_t s;
	scw_spi_st_t n;

	always_comb begin
		n        = s;
		n.done   = 1'b0;
		n.sclk_d = sclk;
		n.cs_d   = cs_n;
		if (s.cs_d && !cs_n) begin
			n.tx  = diag;
			n.cnt = '0;
		end else if (!cs_n) begin
			if (sclk && !s.sclk_d) begin
				n.rx = {di, s.rx[15:1]};
				if (s.cnt != 6'h3f) begin
					n.cnt = s.cnt + 6'h1;
				end
			end
			if (!sclk && s.sclk_d) begin
				// Received bits follow the diagnosis out, so a chain passes words on
				n.tx = {s.rx[15], s.tx[15:1]};
			end
		end else if (!s.cs_d) begin
			// Multiples of 16 bits up to 48 count; the last 16 received are kept
			if (s.cnt != 6'h00 && s.cnt[3:0] == 4'h0) begin
				n.word = s.rx;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '{sclk_d: 1'b0, cs_d: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end

	assign word   = s.word;
	assign done   = s.done;
	assign sdo    = s.tx[0];
	assign sdo_oe = ~s.cs_d;
endmodule : scw_serial

//--- hdl/scw_top.sv
// Supervisor logic: serial control, rail resets, window watchdog, wake and fault pin
//
// Function
// - Rail resets held, released after delay
// - Reset delay 8 ms, selectable 16/32/64
// - Cold start restores default settings
// - First retention flag on main below 2.3V
// - Second retention flag on rail below 1.4V
// - Retention flags cleared after each 16/32/48 bit transfer
// - Fault pin low during any fault but temperature shutdown
// - Watchdog off until enable pattern written
// - Service taken at chip select rise
// - Kick with new timing restarts closed window
// - First closed window after reset delay
// - Watchdog error: fault now, reset later
// - Temperature warning sets error, temp flags
// - Wake by level or 50 us pulse
// - Sleep bit zero powers down if wake low
// - Control word shifted in LSB first
// - Diagnosis shifted out alongside input
// - Chip select frames transfer, output released
// - Daisy chain, 16 bit units
// - Per tracker enable and short report
// - Control word tracker, sleep, kick layout
// - Delay and window field encodings
// - Watchdog on only for pattern 010
// - Diagnosis word layout
`timescale 1ns/100ps
`include "scw_map.svh"
module scw_top
	import scw_pkg::*;
#(
	parameter logic [17:0] TICK_CYCLES = 18'((`SCW_TICK_US * 1000) / `SCW_CLK_PERIOD_NS),
	parameter logic [17:0] WAKE_CYCLES =
		18'((`SCW_WAKE_MIN_US * 1000 + `SCW_CLK_PERIOD_NS - 1) / `SCW_CLK_PERIOD_NS)
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_di,
	output logic            spi_do,
	output logic            spi_do_oe,
	input  wire logic       wake,
	input  wire logic [2:0] rail_ok,
	input  wire logic       main_below_cold,
	input  wire logic       main_below_2v3,
	input  wire logic       second_below_1v4,
	input  wire logic       temp_warn,
	input  wire logic       temp_shutdown,
	input  wire logic [5:0] follower_settled,
	output logic [5:0]      sensor_follower_en,
	output logic            regulators_on,
	output logic            rail_one_reset_n,
	output logic            rail_one_reset_n_oe,
	output logic            rail_two_reset_n,
	output logic            rail_two_reset_n_oe,
	output logic            rail_three_reset_n,
	output logic            rail_three_reset_n_oe,
	output logic            fault_n
);

	////////////////////////////////////////////////////////////////////////////////
	// Field decoding

	function automatic logic [7:0] delay_ms(input logic [15:0] c);
		logic [1:0] f;
		f = {c[`SCW_B_DLY_A], c[`SCW_B_DLY_B]};
		case (f)
			2'h0:    delay_ms = `SCW_DLY_64MS;
			2'h2:    delay_ms = `SCW_DLY_32MS;
			2'h1:    delay_ms = `SCW_DLY_16MS;
			default: delay_ms = `SCW_DLY_8MS;
		endcase
	endfunction : delay_ms

	function automatic logic [7:0] window_ms(input logic [15:0] c);
		logic [1:0] f;
		f = {c[`SCW_B_WIN_A], c[`SCW_B_WIN_B]};
		case (f)
			2'h0:    window_ms = `SCW_WIN_128MS;
			2'h2:    window_ms = `SCW_WIN_64MS;
			2'h1:    window_ms = `SCW_WIN_32MS;
			default: window_ms = `SCW_WIN_16MS;
		endcase
	endfunction : window_ms

	function automatic logic wd_enabled(input logic [15:0] c);
		// Single pattern 0,1,0 on the three off bits; anything else keeps it off
		wd_enabled = !c[`SCW_B_WD_OFF1] && c[`SCW_B_WD_OFF2] && !c[`SCW_B_WD_OFF3];
	endfunction : wd_enabled

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	localparam int          SYN_W    = 18;
	localparam logic [17:0] SYN_INIT = 18'h00002;
	localparam logic [17:0] TICK_M1  = TICK_CYCLES - 18'h1;
	localparam scw_top_st_t TOP_RST  = '{
		ctrl:    `SCW_CTRL_DEFAULT,
		rst_act: 3'h7,
		wd:      SCW_WD_OFF,
		fault_n: 1'b1,
		default: '0
	};

	logic [SYN_W-1:0] syn_q;
	logic             s_sclk;
	logic             s_cs_n;
	logic             s_di;
	logic             s_wake;
	logic [2:0]       s_rail_ok;
	logic             s_cold;
	logic             s_low1;
	logic             s_low2;
	logic             s_twarn;
	logic             s_tshdn;
	logic [5:0]       s_settled;

	scw_sync #(
		.W    (SYN_W),
		.INIT (SYN_INIT)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({follower_settled, temp_shutdown, temp_warn, second_below_1v4,
		           main_below_2v3, main_below_cold, rail_ok, wake, spi_di, spi_cs_n,
		           spi_sclk}),
		.q       (syn_q)
	);

	assign s_sclk    = syn_q[0];
	assign s_cs_n    = syn_q[1];
	assign s_di      = syn_q[2];
	assign s_wake    = syn_q[3];
	assign s_rail_ok = syn_q[6:4];
	assign s_cold    = syn_q[7];
	assign s_low1    = syn_q[8];
	assign s_low2    = syn_q[9];
	assign s_twarn   = syn_q[10];
	assign s_tshdn   = syn_q[11];
	assign s_settled = syn_q[17:12];

	////////////////////////////////////////////////////////////////////////////////
	// Serial port

	scw_top_st_t s;
	scw_top_st_t n;
	logic [15:0] diag;
	logic [15:0] spi_word;
	logic        spi_done;

	scw_serial u_serial (
		.clk     (clk),
		.sys_rst (sys_rst),
		.sclk    (s_sclk),
		.cs_n    (s_cs_n),
		.di      (s_di),
		.diag    (diag),
		.word    (spi_word),
		.done    (spi_done),
		.sdo     (spi_do),
		.sdo_oe  (spi_do_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Derived conditions

	logic       ms_tick;
	logic       kick;
	logic       wd_force;
	logic [5:0] trk_on;
	logic       trk_fault;
	logic       fault_cond;

	assign ms_tick  = (s.tick_cnt == TICK_M1);
	assign kick     = spi_done && spi_word[`SCW_B_KICK];
	assign wd_force = (s.wd == SCW_WD_FAULT) && ms_tick && (s.wd_cnt == 8'h00);
	assign trk_on   = s.ctrl[`SCW_B_TRK_HI:`SCW_B_TRK_LO];
	// An enabled tracker that has not settled after the settle time is a short
	assign trk_fault = (s.settle == 2'h0) && |(trk_on & ~s_settled);
	assign fault_cond = s_twarn | s.wd_err | (s.wd == SCW_WD_FAULT) | s.ret1 | s.ret2 |
		trk_fault;

	// Diagnosis word, latched into the shifter when chip select falls
	assign diag = {s.reg_on, s.wd_err, s.rst_act, (s.wd == SCW_WD_CLOSED), s.ret2, s.ret1,
		trk_on & s_settled, s_twarn, s.err_l};

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n          = s;
		n.tick_cnt = ms_tick ? 18'h0 : s.tick_cnt + 18'h1;

		// Wake: static level or a pulse at least the minimum length
		if (!s_wake) begin
			n.wake_cnt = 18'h0;
		end else if (s.wake_cnt != WAKE_CYCLES) begin
			n.wake_cnt = s.wake_cnt + 18'h1;
		end
		if (!s.ctrl[`SCW_B_SLEEP] && !s_wake) begin
			n.powered = 1'b0;
		end else if (s.wake_cnt == WAKE_CYCLES) begin
			n.powered = 1'b1;
		end
		n.reg_on = s.powered && !s_tshdn;

		// Control word; a cold start keeps the defaults loaded
		if (s_cold) begin
			n.ctrl = `SCW_CTRL_DEFAULT;
		end else if (spi_done) begin
			n.ctrl = spi_word;
		end

		// Rail resets: count whole ticks after the rail is good, so never short
		for (int i = 0; i < 3; i++) begin
			if (!s_rail_ok[i] || wd_force) begin
				n.rst_act[i] = 1'b1;
				n.rst_cnt[i] = delay_ms(s.ctrl);
			end else if (s.rst_act[i] && ms_tick) begin
				if (s.rst_cnt[i] == 8'h00) begin
					n.rst_act[i] = 1'b0;
				end else begin
					n.rst_cnt[i] = s.rst_cnt[i] - 8'h1;
				end
			end
		end

		// Retention flags: a new drop in the clearing cycle wins
		n.ret1   = s_low1 | (s.ret1 & ~spi_done);
		n.ret2   = s_low2 | (s.ret2 & ~spi_done);
		n.wd_err = (s.wd == SCW_WD_FAULT) | (s.wd_err & ~spi_done);
		// Flags cleared by this transfer must not set the error bit again
		n.err_l  = s_twarn | trk_fault | n.wd_err | n.ret1 | n.ret2 | (s.err_l & ~spi_done);

		// Tracker settle timer restarts on any enable change
		n.trk_prev = trk_on;
		if (trk_on != s.trk_prev) begin
			n.settle = `SCW_SETTLE_MS;
		end else if (ms_tick && s.settle != 2'h0) begin
			n.settle = s.settle - 2'h1;
		end

		// Window watchdog
		case (s.wd)
			SCW_WD_OFF: begin
				if (wd_enabled(s.ctrl)) begin
					n.win_len = window_ms(s.ctrl);
					n.wd_cnt  = window_ms(s.ctrl);
					n.wd      = s.rst_act[0] ? SCW_WD_WAIT : SCW_WD_CLOSED;
				end
			end
			SCW_WD_WAIT: begin
				if (!s.rst_act[0]) begin
					n.win_len = window_ms(s.ctrl);
					n.wd_cnt  = window_ms(s.ctrl);
					n.wd      = SCW_WD_CLOSED;
				end
			end
			SCW_WD_CLOSED: begin
				if (kick) begin
					n.wd_cnt = {1'b0, s.win_len[7:1]};
					n.wd     = SCW_WD_FAULT;
				end else if (ms_tick) begin
					if (s.wd_cnt == 8'h00) begin
						n.wd_cnt = s.win_len;
						n.wd     = SCW_WD_OPEN;
					end else begin
						n.wd_cnt = s.wd_cnt - 8'h1;
					end
				end
			end
			SCW_WD_OPEN: begin
				if (kick) begin
					// The kicking word's timing takes effect from this closed window
					n.win_len = window_ms(spi_word);
					n.wd_cnt  = window_ms(spi_word);
					n.wd      = SCW_WD_CLOSED;
				end else if (ms_tick) begin
					if (s.wd_cnt == 8'h00) begin
						n.wd_cnt = {1'b0, s.win_len[7:1]};
						n.wd     = SCW_WD_FAULT;
					end else begin
						n.wd_cnt = s.wd_cnt - 8'h1;
					end
				end
			end
			SCW_WD_FAULT: begin
				if (ms_tick) begin
					if (s.wd_cnt == 8'h00) begin
						n.wd = SCW_WD_WAIT;
					end else begin
						n.wd_cnt = s.wd_cnt - 8'h1;
					end
				end
			end
			default: begin
				n.wd = SCW_WD_OFF;
			end
		endcase
		if (!wd_enabled(s.ctrl)) begin
			// Off clears the counters so a later enable starts a full closed window
			n.wd     = SCW_WD_OFF;
			n.wd_cnt = 8'h00;
		end

		n.fault_n = ~fault_cond;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= TOP_RST;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sensor_follower_en    = trk_on;
	assign regulators_on         = s.reg_on;
	assign rail_one_reset_n      = 1'b0;
	assign rail_two_reset_n      = 1'b0;
	assign rail_three_reset_n    = 1'b0;
	assign rail_one_reset_n_oe   = s.rst_act[0];
	assign rail_two_reset_n_oe   = s.rst_act[1];
	assign rail_three_reset_n_oe = s.rst_act[2];
	assign fault_n               = s.fault_n;
endmodule : scw_top

//--- sim/scw_top_asserts.sv
// Port-level checks of the supervisor logic
`timescale 1ns/100ps
module scw_top_asserts #(
	parameter logic [17:0] TICK_CYCLES = 18'h3d090
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       spi_cs_n,
	input wire logic       spi_do_oe,
	input wire logic       wake,
	input wire logic [2:0] rail_ok,
	input wire logic       temp_warn,
	input wire logic       temp_shutdown,
	input wire logic [5:0] sensor_follower_en,
	input wire logic       regulators_on,
	input wire logic       rail_one_reset_n_oe,
	input wire logic       rail_three_reset_n_oe,
	input wire logic       fault_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [23:0] ok_cnt;
	logic [4:0]  wake_run;
	// Cycles in a row with wake high and no shutdown, held at its ceiling
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_run <= 5'h00;
		end else if (!wake || temp_shutdown) begin
			wake_run <= 5'h00;
		end else if (wake_run != 5'h1f) begin
			wake_run <= wake_run + 5'h01;
		end
	end
	// Counted from the pin, so sync latency only makes the design look later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ok_cnt <= 24'h0;
		else if (!rail_ok[0])
			ok_cnt <= 24'h0;
		else if (ok_cnt != 24'hffffff)
			ok_cnt <= ok_cnt + 24'h1;
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_cs_idle;
		spi_cs_n[*8];
	endsequence
	sequence s_cs_busy;
		!spi_cs_n[*8];
	endsequence
	a_do_released: assert property (s_cs_idle |-> !spi_do_oe)
		else $error("data out driven while deselected");
	a_do_driven: assert property (s_cs_busy |-> spi_do_oe)
		else $error("data out not driven in frame");
	a_main_held: assert property (!rail_ok[0][*6] |-> rail_one_reset_n_oe)
		else $error("main reset released with rail low");
	a_third_held: assert property (!rail_ok[2][*6] |-> rail_three_reset_n_oe)
		else $error("third reset released with rail low");
	a_delay_floor: assert property ($fell(rail_one_reset_n_oe) |->
		ok_cnt >= 24'(8 * TICK_CYCLES) - 24'h8)
		else $error("reset released before delay");
	a_temp_fault: assert property (temp_warn[*6] |-> !fault_n)
		else $error("fault pin high during warning");
	a_word_at_end: assert property ($changed(sensor_follower_en) |->
		spi_cs_n && !spi_do_oe)
		else $error("control changed inside frame");
	a_wake_on: assert property (wake_run >= 5'h0e |-> regulators_on)
		else $error("regulators off with wake high");
	a_shutdown_off: assert property (temp_shutdown[*6] |-> !regulators_on)
		else $error("regulators on in shutdown");
endmodule : scw_top_asserts

bind scw_top scw_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_do_oe(spi_do_oe),
	.wake(wake), .rail_ok(rail_ok), .temp_warn(temp_warn), .temp_shutdown(temp_shutdown),
	.sensor_follower_en(sensor_follower_en), .regulators_on(regulators_on),
	.rail_one_reset_n_oe(rail_one_reset_n_oe), .rail_three_reset_n_oe(rail_three_reset_n_oe),
	.fault_n(fault_n)
);

//--- sim/scw_host.sv
// Host model of the serial link: framed transfers, LSB first
`timescale 1ns/100ps
module scw_host (
	input  wire logic clk,
	input  wire logic spi_do,
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_di
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_di   = 1'b0;
	end
	// Eight clocks high and nine low give a 68 ns serial clock; it stands low between frames
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		@(posedge clk) spi_cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk) spi_di <= tx[i];
			repeat (8) @(posedge clk);
			rx[i] = spi_do;
			spi_sclk <= 1'b1;
			repeat (8) @(posedge clk);
			spi_sclk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		spi_cs_n <= 1'b1;
		spi_di   <= ~spi_di;
		repeat (12) @(posedge clk);
	endtask : xfer
endmodule : scw_host

//--- sim/scw_top_tb.sv
// Self-checking bench of the supervisor logic
`timescale 1ns/100ps
module scw_top_tb;
	logic        clk, sys_rst, spi_sclk, spi_cs_n, spi_di, spi_do, spi_do_oe;
	logic        wake, main_below_cold, main_below_2v3, second_below_1v4;
	logic        temp_warn, temp_shutdown, regulators_on, fault_n;
	logic        r1, r1_oe, r2, r2_oe, r3, r3_oe;
	logic [2:0]  rail_ok;
	logic [5:0]  follower_settled, follower_en;
	logic [31:0] rx;
	int          errors = 0;
	int          checks = 0;
	int          cyc = 0;
	int          n;

	scw_top #(.TICK_CYCLES(18'h10), .WAKE_CYCLES(18'h4)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_di(spi_di), .spi_do(spi_do), .spi_do_oe(spi_do_oe), .wake(wake),
		.rail_ok(rail_ok), .main_below_cold(main_below_cold),
		.main_below_2v3(main_below_2v3), .second_below_1v4(second_below_1v4),
		.temp_warn(temp_warn), .temp_shutdown(temp_shutdown),
		.follower_settled(follower_settled), .sensor_follower_en(follower_en),
		.regulators_on(regulators_on), .rail_one_reset_n(r1), .rail_one_reset_n_oe(r1_oe),
		.rail_two_reset_n(r2), .rail_two_reset_n_oe(r2_oe), .rail_three_reset_n(r3),
		.rail_three_reset_n_oe(r3_oe), .fault_n(fault_n)
	);
	scw_host host_u (
		.clk(clk), .spi_do(spi_do), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_di(spi_di)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_in(input string what, input int lo, input int hi, input int got);
		checks++;
		if (got < lo || got > hi) begin
			errors++;
			$display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
		end
	endtask : chk_in
	task automatic step(input int k);
		repeat (k) @(posedge clk);
	endtask : step
	task automatic xw(input logic [15:0] w, input logic [15:0] exp);
		host_u.xfer({16'h0, w}, 16, rx);
		chk("diag", {16'h0, exp}, rx);
	endtask : xw
	// Bounded wait on the main rail reset, n holds the cycles spent
	task automatic wait_rst(input logic lvl);
		n = 0;
		while (r1_oe !== lvl && n < 2000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_rst
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		sys_rst = 1'b1;
		wake = 1'b1;
		rail_ok = 3'h0;
		main_below_cold = 1'b0;
		main_below_2v3 = 1'b0;
		second_below_1v4 = 1'b0;
		temp_warn = 1'b0;
		temp_shutdown = 1'b0;
		follower_settled = 6'h3f;
		step(10);
		sys_rst <= 1'b0;
		step(20);
		chk("main reset", 1, r1_oe);
		chk("all resets", 3'h7, {r3_oe, r2_oe, r1_oe});
		chk("reset data", 3'h0, {r3, r2, r1});
		chk("power", 1, regulators_on);
		rail_ok <= 3'h7;
		wait_rst(0);
		chk_in("delay", 128, 152, n);
		chk("all resets", 3'h0, {r3_oe, r2_oe, r1_oe});
		main_below_2v3 <= 1'b1;
		second_below_1v4 <= 1'b1;
		step(8);
		main_below_2v3 <= 1'b0;
		second_below_1v4 <= 1'b0;
		step(8);
		chk("fault", 0, fault_n);
		xw(16'h4dfd, 16'h83fd);
		xw(16'h4dfd, 16'h80fc);
		chk("fault", 1, fault_n);
		xw(16'h4da9, 16'h80fc);
		chk("trackers", 6'h2a, follower_en);
		follower_settled <= 6'h28;
		step(60);
		chk("fault", 0, fault_n);
		follower_settled <= 6'h3f;
		step(8);
		xw(16'h4da9, 16'h80a9);
		host_u.xfer(32'h0000_00fd, 8, rx);
		chk("trackers", 6'h2a, follower_en);
		host_u.xfer(32'h4dfd_1234, 32, rx);
		chk("chain", 32'h1234_80a8, rx);
		chk("trackers", 6'h3f, follower_en);
		temp_warn <= 1'b1;
		step(8);
		xw(16'h4dfd, 16'h80ff);
		temp_warn <= 1'b0;
		step(4);
		xw(16'h4dfd, 16'h80fd);
		xw(16'h4cfd, 16'h80fc);
		step(20);
		chk("power", 1, regulators_on);
		wake <= 1'b0;
		step(12);
		chk("power", 0, regulators_on);
		wake <= 1'b1;
		step(20);
		chk("power", 1, regulators_on);
		wait_rst(0);
		xw(16'h4da9, 16'h80fc);
		main_below_cold <= 1'b1;
		step(8);
		main_below_cold <= 1'b0;
		step(4);
		chk("trackers", 6'h3f, follower_en);
		// Watchdog has been off for many windows, so the enable gap is kept
		xw(16'h2ffc, 16'h80fc);
		step(300);
		xw(16'haffc, 16'h84fc);
		chk("fault", 1, fault_n);
		xw(16'haffc, 16'h84fc);
		chk("fault", 0, fault_n);
		wait_rst(1);
		chk_in("half window", 236, 280, n);
		chk("all resets", 3'h7, {r3_oe, r2_oe, r1_oe});
		wait_rst(0);
		chk_in("redelay", 120, 150, n);
		xw(16'h4dfd, 16'hc4fd);
		xw(16'h4dfd, 16'h80fc);
		chk("fault", 1, fault_n);
		temp_shutdown <= 1'b1;
		step(8);
		chk("power", 0, regulators_on);
		temp_shutdown <= 1'b0;
		complete_run();
	end
endmodule : scw_top_tb
